/* File: include/dmi_cfg.svh */
/*
 data memory block: addresses, command fields and reset values.
 assumes it is included by every design file that decodes the map.
*/
`ifndef DMI_CFG_SVH
`define DMI_CFG_SVH

`define DMI_A_PORT0 8'h00
`define DMI_A_PTR0 8'h01
`define DMI_A_PORT1 8'h02
`define DMI_A_PTR1 8'h03
`define DMI_A_UNUSED 8'h04
`define DMI_A_ACC 8'h05
`define DMI_A_PCL 8'h06
`define DMI_A_TBLP 8'h07
`define DMI_A_TBLH 8'h08
`define DMI_GP_BIT 7

`define DMI_IDX_BITOP 10'h100
`define DMI_IDX_XFER 10'h101
`define DMI_IDX_HI 11
`define DMI_IDX_LO 2

`define DMI_CMD_BIT_LO 8
`define DMI_CMD_BIT_HI 10
`define DMI_CMD_SET 11
`define DMI_CMD_DIR 8

`define DMI_BYTE_ZERO 8'h00
`define DMI_PC_RESET 0

`endif

/* File: include/dmi_pkg.sv */
/*
 data memory block: shared types.
 assumes dmi_cfg.svh supplies the numeric constants.
*/
package dmi_pkg;
	typedef logic [7:0] dmi_byte_t;
	typedef logic [2:0] dmi_bitsel_t;
	typedef enum logic [1:0] {
		DMI_APB_IDLE = 2'b01,
		DMI_APB_ANS = 2'b10
	} dmi_apb_t;
endpackage : dmi_pkg

/* File: core/dmi_ind_res.sv */
/*
 indirect port resolver: maps one virtual port onto the byte its pointer holds.
 assumes a single bank; the pointer is a plain register of the caller.
*/
`timescale 1ns/1ps
`include "dmi_cfg.svh"
module dmi_ind_res #(
	parameter dmi_pkg::dmi_byte_t SELF_PORT = `DMI_A_PORT0,
	parameter dmi_pkg::dmi_byte_t OTHER_PORT = `DMI_A_PORT1
) (
	// request
	input wire dmi_pkg::dmi_byte_t addr_in,
	input wire dmi_pkg::dmi_byte_t ptr,
	// result
	output logic hit,
	output logic no_target,
	output dmi_pkg::dmi_byte_t addr_out
);
	import dmi_pkg::*;

	always_comb begin
		hit = (addr_in == SELF_PORT);
		addr_out = ptr;
		// a pointer aimed at any port has nothing behind it
		no_target = (ptr == SELF_PORT) || (ptr == OTHER_PORT);
	end
endmodule : dmi_ind_res

/* File: core/dmi_bit_mod.sv */
/*
 single-bit set or clear on one byte.
 assumes the caller supplies the current byte combinationally.
*/
`timescale 1ns/1ps
module dmi_bit_mod (
	// operand
	input wire dmi_pkg::dmi_byte_t din,
	input wire dmi_pkg::dmi_bitsel_t sel,
	input wire logic set,
	// result
	output dmi_pkg::dmi_byte_t dout
);
	import dmi_pkg::*;

	always_comb begin
		dout = din;
		dout[sel] = set;
	end
endmodule : dmi_bit_mod

/* File: core/dmi_data_mem.sv */
/*
 data memory with indirect ports, accumulator and program counter low byte.
 assumes an apb master on pclk and a core that drives the alu and pc ports.
*/
// How it works
// - one volatile 8-bit bank, bank zero
// - sfr area 00-7f, 128 bytes at 80-ff
// - general bytes read, write, bit set/clear
// - unused sfr reads zero, writes ignored
// - protected sfr is read only
// - port access goes to paired pointer address
// - pointer at a port: read zero, no write
// - pointers are ordinary read/write registers
// - pair zero bank zero, pair one any bank
// - direct access reaches bank zero only
// - memory moves go through the accumulator
// - accumulator captures alu results
// - pcl write jumps within current page
// - one dummy cycle after pcl write
`timescale 1ns/1ps
`include "dmi_cfg.svh"
module dmi_data_mem #(
	parameter int PC_W = 10,
	parameter int GP_DEPTH = 128
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// core side
	input wire logic alu_we,
	input wire dmi_pkg::dmi_byte_t alu_res,
	input wire logic pc_inc,
	input wire dmi_pkg::dmi_byte_t tbl_high_in,
	output logic [PC_W-1:0] pc,
	output logic core_stall,
	output dmi_pkg::dmi_byte_t acc
);
	import dmi_pkg::*;

	dmi_byte_t mem_r [GP_DEPTH];
	dmi_byte_t ptr0_r;
	dmi_byte_t ptr1_r;
	dmi_byte_t acc_r;
	dmi_byte_t tblp_r;
	dmi_byte_t tblh_r;
	logic [PC_W-1:0] pc_r;
	logic stall_r;
	logic [11:0] bitop_r;
	logic [8:0] xfer_r;
	dmi_apb_t st_r;
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;

	logic [9:0] idx;
	logic map_acc;
	logic is_bitop;
	logic is_xfer;
	logic bad;
	dmi_byte_t tgt;
	dmi_byte_t a0;
	dmi_byte_t a1;
	dmi_byte_t ea;
	logic hit0;
	logic hit1;
	logic void0;
	logic void1;
	logic vd;
	dmi_byte_t rd_val;
	dmi_byte_t bit_val;
	dmi_byte_t wr_val;
	logic done;
	logic wr_go;
	logic acc_load;
	logic [31:0] rd_word;

	// map decode; a printed offset is a word index, byte address is four times it
	always_comb begin
		idx = paddr[`DMI_IDX_HI:`DMI_IDX_LO];
		map_acc = (idx[9:8] == 2'b00);
		is_bitop = (idx == `DMI_IDX_BITOP);
		is_xfer = (idx == `DMI_IDX_XFER);
		bad = !(map_acc || is_bitop || is_xfer);
		// commands name their own target byte
		tgt = map_acc ? idx[7:0] : pwdata[7:0];
	end

	dmi_ind_res #(
		.SELF_PORT(`DMI_A_PORT0),
		.OTHER_PORT(`DMI_A_PORT1)
	) u_res0 (
		.addr_in(tgt),
		.ptr(ptr0_r),
		.hit(hit0),
		.no_target(void0),
		.addr_out(a0)
	);

	dmi_ind_res #(
		.SELF_PORT(`DMI_A_PORT1),
		.OTHER_PORT(`DMI_A_PORT0)
	) u_res1 (
		.addr_in(tgt),
		.ptr(ptr1_r),
		.hit(hit1),
		.no_target(void1),
		.addr_out(a1)
	);

	// only bank zero exists, so pair one reaches everything pair zero does
	always_comb begin
		ea = tgt;
		vd = 1'b0;
		if (hit0) begin
			ea = a0;
			vd = void0;
		end else if (hit1) begin
			ea = a1;
			vd = void1;
		end
	end

	// read mux over the single bank
	always_comb begin
		rd_val = `DMI_BYTE_ZERO;
		if (!vd) begin
			if (ea[`DMI_GP_BIT]) begin
				rd_val = mem_r[ea[6:0]];
			end else begin
				unique case (ea)
					`DMI_A_PTR0: rd_val = ptr0_r;
					`DMI_A_PTR1: rd_val = ptr1_r;
					`DMI_A_ACC: rd_val = acc_r;
					`DMI_A_PCL: rd_val = pc_r[7:0];
					`DMI_A_TBLP: rd_val = tblp_r;
					`DMI_A_TBLH: rd_val = tblh_r;
					default: rd_val = `DMI_BYTE_ZERO;
				endcase
			end
		end
	end

	dmi_bit_mod u_bit (
		.din(rd_val),
		.sel(pwdata[`DMI_CMD_BIT_HI:`DMI_CMD_BIT_LO]),
		.set(pwdata[`DMI_CMD_SET]),
		.dout(bit_val)
	);

	// every register write from apb happens on the edge that completes the apb transfer
	always_comb begin
		done = psel && penable && pready_r;
		// no memory-to-memory move exists; xfer only loads or stores acc
		acc_load = done && pwrite && is_xfer && !pwdata[`DMI_CMD_DIR];
		wr_go = done && pwrite && !vd
			&& (map_acc || is_bitop || (is_xfer && pwdata[`DMI_CMD_DIR]));
		wr_val = pwdata[7:0];
		if (is_bitop) begin
			wr_val = bit_val;
		end else if (is_xfer) begin
			wr_val = acc_r;
		end
		rd_word = {24'h000000, rd_val};
		if (is_bitop) begin
			rd_word = {20'h00000, bitop_r};
		end else if (is_xfer) begin
			rd_word = {23'h000000, xfer_r};
		end
	end

	// apb answer: one wait state, then pready for a single cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= DMI_APB_IDLE;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h00000000;
		end else begin
			unique case (st_r)
				DMI_APB_IDLE: begin
					if (psel && penable) begin
						st_r <= DMI_APB_ANS;
						pready_r <= 1'b1;
						pslverr_r <= bad;
						prdata_r <= (pwrite || bad) ? 32'h00000000 : rd_word;
					end
				end
				DMI_APB_ANS: begin
					st_r <= DMI_APB_IDLE;
					pready_r <= 1'b0;
					pslverr_r <= 1'b0;
				end
				default: st_r <= DMI_APB_IDLE;
			endcase
		end
	end

	// data storage has no reset, as a volatile ram would not
	always_ff @(posedge pclk) begin
		if (wr_go && ea[`DMI_GP_BIT]) begin
			mem_r[ea[6:0]] <= wr_val;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ptr0_r <= `DMI_BYTE_ZERO;
			ptr1_r <= `DMI_BYTE_ZERO;
			tblp_r <= `DMI_BYTE_ZERO;
		end else if (wr_go) begin
			if (ea == `DMI_A_PTR0) begin
				ptr0_r <= wr_val;
			end
			if (ea == `DMI_A_PTR1) begin
				ptr1_r <= wr_val;
			end
			if (ea == `DMI_A_TBLP) begin
				tblp_r <= wr_val;
			end
		end
	end

	// protected: follows the core only, program writes fall through
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tblh_r <= `DMI_BYTE_ZERO;
		end else begin
			tblh_r <= tbl_high_in;
		end
	end

	// a program write wins over the alu in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_r <= `DMI_BYTE_ZERO;
		end else if (wr_go && ea == `DMI_A_ACC) begin
			acc_r <= wr_val;
		end else if (acc_load) begin
			acc_r <= rd_val;
		end else if (alu_we) begin
			acc_r <= alu_res;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bitop_r <= 12'h000;
			xfer_r <= 9'h000;
		end else if (done && pwrite) begin
			if (is_bitop) begin
				bitop_r <= pwdata[11:0];
			end
			if (is_xfer) begin
				xfer_r <= pwdata[8:0];
			end
		end
	end

	// page bits are kept, so the jump cannot leave the current page
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_r <= PC_W'(`DMI_PC_RESET);
			stall_r <= 1'b0;
		end else begin
			stall_r <= 1'b0;
			if (wr_go && ea == `DMI_A_PCL) begin
				pc_r <= {pc_r[PC_W-1:8], wr_val};
				stall_r <= 1'b1;
			end else if (pc_inc && !stall_r) begin
				pc_r <= pc_r + PC_W'(1);
			end
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign pc = pc_r;
	assign core_stall = stall_r;
	assign acc = acc_r;

	AST_UNUSED_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && penable && !pready_r && !pwrite && idx == 10'({2'b00, `DMI_A_UNUSED}))
		|=> (prdata == 32'h00000000 && pready))
		else $error("unused location did not read zero");

	AST_VOID_PORT: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && penable && !pready_r && !pwrite && map_acc && hit0
		&& (ptr0_r == `DMI_A_PORT0 || ptr0_r == `DMI_A_PORT1))
		|=> (prdata == 32'h00000000))
		else $error("port aimed at a port did not read zero");

	AST_IND_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
		(done && pwrite && map_acc && hit0 && ptr0_r[`DMI_GP_BIT])
		|=> (mem_r[$past(ptr0_r[6:0])] == $past(pwdata[7:0])))
		else $error("indirect write missed the pointed byte");

	AST_BIT_OP: assert property (@(posedge pclk) disable iff (!presetn)
		(done && pwrite && is_bitop && !vd && ea[`DMI_GP_BIT])
		|=> (mem_r[$past(ea[6:0])][$past(pwdata[10:8])] == $past(pwdata[`DMI_CMD_SET])))
		else $error("bit operation left the bit wrong");

	AST_PTR_STORE: assert property (@(posedge pclk) disable iff (!presetn)
		(done && pwrite && map_acc && idx == 10'({2'b00, `DMI_A_PTR1}))
		|=> (ptr1_r == $past(pwdata[7:0])))
		else $error("pointer one did not take the written value");

	AST_RO_REG: assert property (@(posedge pclk) disable iff (!presetn)
		(done && pwrite && ea == `DMI_A_TBLH) |=> (tblh_r == $past(tbl_high_in)))
		else $error("protected register took a program write");

	AST_ALU_CAPTURE: assert property (@(posedge pclk) disable iff (!presetn)
		(alu_we && !done) |=> (acc == $past(alu_res)))
		else $error("accumulator missed an alu result");

	AST_PAGE_JUMP: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_go && ea == `DMI_A_PCL)
		|=> (pc[7:0] == $past(wr_val) && pc[PC_W-1:8] == $past(pc_r[PC_W-1:8])))
		else $error("pcl write did not jump within the page");

	AST_DUMMY_CYCLE: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_go && ea == `DMI_A_PCL) |=> core_stall ##1 ($stable(pc) && !core_stall))
		else $error("no single dummy cycle after pcl write");

	AST_READY_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
		pready |=> !pready)
		else $error("pready held longer than one cycle");
endmodule : dmi_data_mem

/* File: test/dmi_core_model.sv */
/*
 core-side partner: drives alu results, pc advance and table high byte.
 assumes pclk from the bench; all changes land just after a rising edge.
*/
`timescale 1ns/1ps
module dmi_core_model (
	// clock
	input wire logic pclk,
	// core outputs
	output logic alu_we,
	output dmi_pkg::dmi_byte_t alu_res,
	output logic pc_inc,
	output dmi_pkg::dmi_byte_t tbl_high_in
);
	import dmi_pkg::*;
	initial begin
		alu_we = 1'b0;
		alu_res = 8'h00;
		pc_inc = 1'b0;
		tbl_high_in = 8'h6B;
	end
	// one capture cycle per result
	task automatic alu(input dmi_byte_t v);
		@(posedge pclk);
		alu_we <= 1'b1;
		alu_res <= v;
		@(posedge pclk);
		alu_we <= 1'b0;
		alu_res <= ~v;
	endtask : alu
	// held high for n edges, so pc moves by n
	task automatic inc(input int n);
		@(posedge pclk);
		pc_inc <= 1'b1;
		repeat (n) @(posedge pclk);
		pc_inc <= 1'b0;
	endtask : inc
endmodule : dmi_core_model

/* File: test/data_memory_indirect_access_test.sv */
/*
 self-checking bench for the data memory block over apb.
 assumes a 2-cycle apb access phase and the core model beside it.
*/
`timescale 1ns/1ps
module data_memory_indirect_access_test;
	import dmi_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, core_stall;
	logic alu_we, pc_inc;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [9:0] pc;
	dmi_byte_t alu_res, tbl_high_in, acc;
	int mismatches = 0;
	int checks_done = 0;
	dmi_data_mem uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .alu_we(alu_we), .alu_res(alu_res),
		.pc_inc(pc_inc), .tbl_high_in(tbl_high_in), .pc(pc), .core_stall(core_stall),
		.acc(acc));
	dmi_core_model core (.pclk(pclk), .alu_we(alu_we), .alu_res(alu_res),
		.pc_inc(pc_inc), .tbl_high_in(tbl_high_in));
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	// waits on pready, never on a fixed count
	task automatic apb(input logic w, input logic [9:0] i, input logic [11:0] d,
		output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {i, 2'b00};
		pwdata <= {20'h00000, d};
		@(posedge pclk);
		penable <= 1'b1;
		// a hang here is ended by the watchdog, which counts it as a mismatch
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [9:0] i, input logic [11:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, i, d, q, e);
	endtask : wr
	task automatic rc(input logic [9:0] i, input logic [31:0] exp);
		logic [31:0] q;
		logic e;
		apb(1'b0, i, 12'h000, q, e);
		chk(q, exp);
	endtask : rc
	task automatic sc_regs;
		logic [31:0] q;
		logic e;
		rc(10'h001, 32'h0);
		wr(10'h001, 12'h0C3);
		rc(10'h001, 32'hC3);
		wr(10'h003, 12'h0FF);
		rc(10'h003, 32'hFF);
		wr(10'h004, 12'h0FF);
		rc(10'h004, 32'h0);
		wr(10'h040, 12'h055);
		rc(10'h040, 32'h0);
		wr(10'h008, 12'h011);
		rc(10'h008, 32'h6B);
		apb(1'b0, 10'h102, 12'h000, q, e);
		chk(e, 1'b1);
	endtask : sc_regs
	task automatic sc_gp;
		wr(10'h080, 12'h000);
		wr(10'h0FF, 12'h0A7);
		rc(10'h0FF, 32'hA7);
		wr(10'h0FE, 12'hF5A);
		rc(10'h0FE, 32'h5A);
		wr(10'h100, 12'h880);
		wr(10'h100, 12'hF80);
		wr(10'h100, 12'h080);
		rc(10'h080, 32'h80);
	endtask : sc_gp
	task automatic sc_ind;
		wr(10'h001, 12'h090);
		wr(10'h000, 12'h0A5);
		rc(10'h090, 32'hA5);
		wr(10'h003, 12'h091);
		wr(10'h002, 12'h05A);
		rc(10'h091, 32'h5A);
		wr(10'h001, 12'h004);
		rc(10'h000, 32'h0);
		wr(10'h001, 12'h002);
		wr(10'h000, 12'h077);
		rc(10'h000, 32'h0);
		rc(10'h002, 32'h5A);
	endtask : sc_ind
	task automatic sc_acc;
		wr(10'h081, 12'h03C);
		wr(10'h101, 12'h081);
		rc(10'h005, 32'h3C);
		wr(10'h101, 12'h182);
		rc(10'h082, 32'h3C);
		core.alu(8'h99);
		rc(10'h005, 32'h99);
		chk(acc, 8'h99);
	endtask : sc_acc
	// 260 steps put a nonzero page in the high pc bits
	task automatic sc_pcl;
		core.inc(260);
		#1 chk(pc, 10'h104);
		wr(10'h006, 12'h033);
		#1 chk(pc, 10'h133);
		chk(core_stall, 1'b1);
		@(posedge pclk);
		#1 chk(core_stall, 1'b0);
		rc(10'h006, 32'h33);
		// pc_inc stays high across a pcl write: the dummy cycle swallows one step
		fork
			core.inc(20);
			wr(10'h006, 12'h033);
		join
		#1 chk(pc, 10'h143);
	endtask : sc_pcl
	task automatic results;
		if (mismatches == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : results
	initial begin
		#(25 * 4000);
		mismatches++;
		results();
	end
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		sc_regs();
		sc_gp();
		sc_ind();
		sc_acc();
		sc_pcl();
		results();
	end
endmodule : data_memory_indirect_access_test
